// >>> logic/hsim_defs.vh
// Register map, field positions and reset values of the HDLC status and mask block
`ifndef HSIM_DEFS_VH
`define HSIM_DEFS_VH
`define HSIM_ADDR_W 8
`define HSIM_OFF_MASK 8'hB2
`define HSIM_OFF_RXINFO 8'hB3
`define HSIM_OFF_STATUS 8'hB1
`define HSIM_OFF_IRQEN 8'hB9
`define HSIM_MASK_RESET 8'h00
`define HSIM_MASK_USED 8'h7F
`define HSIM_IRQEN_RESET 1'b1
`define HSIM_FIFO_DEPTH 64
`define HSIM_FIFO_HALF 32
`define HSIM_BIT_TX_MESSAGE_DONE 0
`define HSIM_BIT_TXROOM 1
`define HSIM_BIT_TXHALF 2
`define HSIM_BIT_RXNE 3
`define HSIM_BIT_RXHALF 4
`define HSIM_BIT_RPS 5
`define HSIM_BIT_RPE 6
`define HSIM_RI_OPEN 0
`define HSIM_RI_CLOSE 1
`define HSIM_RI_GOOD 2
`define HSIM_RI_EMPTY 3
`define HSIM_RI_VALID 4
`define HSIM_RI_OVR 5
`define HSIM_RI_CRC 6
`define HSIM_RI_ABT 7
`endif

// >>> logic/hsim_level_flags.v
// FIFO level comparator producing the live status levels
`timescale 1ns/1ns
module hsim_level_flags #(
	parameter DEPTH = 64,
	parameter HALF = 32,
	parameter CW = 7
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Occupancy
	input wire [CW-1:0] rxCount,
	input wire [CW-1:0] txCount,
	// Levels
	output reg txRoom,
	output reg txHalfEmpty,
	output reg rxHalfFull,
	output reg rxNotEmpty,
	output reg rxEmpty
);
	localparam [CW-1:0] DEPTH_C = DEPTH[CW-1:0];
	localparam [CW-1:0] HALF_C = HALF[CW-1:0];
	// Registered so that status bits are glitch free when sampled by the bus
	always @(posedge core_clk) begin
		if (reset) begin
			txRoom <= 1'b1;
			txHalfEmpty <= 1'b1;
			rxHalfFull <= 1'b0;
			rxNotEmpty <= 1'b0;
			rxEmpty <= 1'b1;
		end else begin
			txRoom <= (txCount < DEPTH_C);
			txHalfEmpty <= (txCount < HALF_C);
			rxHalfFull <= (rxCount > HALF_C);
			rxNotEmpty <= (rxCount != {CW{1'b0}});
			rxEmpty <= (rxCount == {CW{1'b0}});
		end
	end
endmodule // hsim_level_flags

// >>> logic/hsim_status_irq.v
// HDLC status, interrupt mask and receive information registers on Wishbone
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "hsim_defs.vh"
module hsim_status_irq #(
	parameter FIFO_DEPTH = `HSIM_FIFO_DEPTH,
	parameter FIFO_HALF = `HSIM_FIFO_HALF,
	parameter CW = 7
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`HSIM_ADDR_W-1:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// FIFO occupancy from the framing engine
	input wire [CW-1:0] rxFifoCount,
	input wire [CW-1:0] txFifoCount,
	// Event pulses from the framing engine
	input wire txMessageDone,
	input wire rxPacketStart,
	input wire rxPacketEnd,
	input wire rxAbortSeen,
	input wire rxCrcError,
	input wire rxOverrun,
	input wire rxValidFrame,
	// Tags of the byte at the receive FIFO head
	input wire headIsFirst,
	input wire headIsLast,
	input wire headIsGood,
	// Interrupt
	output reg hdlcIrq
);
	// Status and info latches
	reg txMessageDoneFlag;
	reg rxPacketStartFlag;
	reg rxPacketEndFlag;
	reg rxAbortFlag;
	reg rxCrcFlag;
	reg rxOverrunFlag;
	reg rxValidFlag;
	reg [7:0] irqMask;
	reg irqEnable;
	wire txRoom;
	wire txHalfEmpty;
	wire rxHalfFull;
	wire rxNotEmpty;
	wire rxEmpty;
	wire [7:0] statusWord;
	wire [7:0] infoWord;
	wire busReq;
	wire readStatus;
	wire readInfo;
	reg [31:0] next_dat;

	// Bus sequencer states; the acknowledge stands one cycle
	localparam [0:0] BUS_IDLE = 1'b0;
	localparam [0:0] BUS_ACK = 1'b1;
	reg [0:0] busState;
	reg [0:0] next_busState;

	// Address decode of the mapped registers
	wire selStatus;
	wire selMask;
	wire selInfo;
	wire selEnable;
	wire writeLane0;
	wire writeMask;
	wire writeEnable;

	// Unmasked sources that currently want the interrupt line
	wire [6:0] pendingSources;
	wire headGood;

	// Sticky flag update: a set in the clearing cycle wins
	function latch_next;
		input flag;
		input setEv;
		input clrEv;
		begin
			latch_next = setEv | (flag & ~clrEv);
		end
	endfunction

	function hit;
		input [`HSIM_ADDR_W-1:0] adr;
		input [`HSIM_ADDR_W-1:0] off;
		begin
			hit = (adr == off);
		end
	endfunction

	hsim_level_flags #(
		.DEPTH(FIFO_DEPTH),
		.HALF(FIFO_HALF),
		.CW(CW)
	) levels (
		.core_clk(core_clk),
		.reset(reset),
		.rxCount(rxFifoCount),
		.txCount(txFifoCount),
		.txRoom(txRoom),
		.txHalfEmpty(txHalfEmpty),
		.rxHalfFull(rxHalfFull),
		.rxNotEmpty(rxNotEmpty),
		.rxEmpty(rxEmpty)
	);

	// Decode for the access strobes; the read data select decodes the same offsets again in its own case
	assign selStatus = hit(wb_adr_i, `HSIM_OFF_STATUS);
	assign selMask = hit(wb_adr_i, `HSIM_OFF_MASK);
	assign selInfo = hit(wb_adr_i, `HSIM_OFF_RXINFO);
	assign selEnable = hit(wb_adr_i, `HSIM_OFF_IRQEN);

	// One access per request: a new request is taken only from the idle state
	// A master that holds cyc through the ack cycle is therefore not served twice
	assign busReq = wb_cyc_i & wb_stb_i & (busState == BUS_IDLE);
	assign readStatus = busReq & ~wb_we_i & selStatus;
	assign readInfo = busReq & ~wb_we_i & selInfo;
	assign writeLane0 = busReq & wb_we_i & wb_sel_i[0];
	assign writeMask = writeLane0 & selMask;
	assign writeEnable = writeLane0 & selEnable;

	// Status word, one bit at a time
	assign statusWord[`HSIM_BIT_TX_MESSAGE_DONE] = txMessageDoneFlag;
	assign statusWord[`HSIM_BIT_TXROOM] = txRoom;
	assign statusWord[`HSIM_BIT_TXHALF] = txHalfEmpty;
	assign statusWord[`HSIM_BIT_RXNE] = rxNotEmpty;
	assign statusWord[`HSIM_BIT_RXHALF] = rxHalfFull;
	assign statusWord[`HSIM_BIT_RPS] = rxPacketStartFlag;
	assign statusWord[`HSIM_BIT_RPE] = rxPacketEndFlag;
	assign statusWord[7] = 1'b0;

	// Receive info word; the head tags are live and never latched
	assign headGood = headIsGood & headIsLast;
	assign infoWord[`HSIM_RI_OPEN] = headIsFirst;
	assign infoWord[`HSIM_RI_CLOSE] = headIsLast;
	assign infoWord[`HSIM_RI_GOOD] = headGood;
	assign infoWord[`HSIM_RI_EMPTY] = rxEmpty;
	assign infoWord[`HSIM_RI_VALID] = rxValidFlag;
	assign infoWord[`HSIM_RI_OVR] = rxOverrunFlag;
	assign infoWord[`HSIM_RI_CRC] = rxCrcFlag;
	assign infoWord[`HSIM_RI_ABT] = rxAbortFlag;

	// Read data select
	// Unmapped offsets read as zero so software can probe the map safely
	always @* begin
		next_dat = 32'h00000000;
		case (wb_adr_i)
			`HSIM_OFF_STATUS: begin
				next_dat[7:0] = statusWord;
			end
			`HSIM_OFF_MASK: begin
				next_dat[7:0] = irqMask;
			end
			`HSIM_OFF_RXINFO: begin
				next_dat[7:0] = infoWord;
			end
			`HSIM_OFF_IRQEN: begin
				next_dat[0] = irqEnable;
			end
			default: begin
				next_dat = 32'h00000000;
			end
		endcase
	end

	// Bus sequencer: ack follows the taking edge and stands for one cycle
	// Costs one idle cycle between requests, which keeps clear-on-read exact
	always @* begin
		next_busState = busState;
		case (busState)
			BUS_IDLE: begin
				if (wb_cyc_i & wb_stb_i) begin
					next_busState = BUS_ACK;
				end
			end
			BUS_ACK: begin
				next_busState = BUS_IDLE;
			end
			default: begin
				next_busState = BUS_IDLE;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (reset) begin
			busState <= BUS_IDLE;
		end else begin
			busState <= next_busState;
		end
	end

	// Bus acknowledge: one wait state, writes to unmapped offsets are ignored
	always @(posedge core_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= busReq;
		end
	end

	// Read data, held at zero outside the ack cycle
	// Shows the value before any clear taken at the same edge
	always @(posedge core_clk) begin
		if (reset) begin
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_dat_o <= busReq ? next_dat : 32'h00000000;
		end
	end

	// Mask register; bit 7 is not implemented and reads zero
	always @(posedge core_clk) begin
		if (reset) begin
			irqMask <= `HSIM_MASK_RESET;
		end else if (writeMask) begin
			irqMask <= wb_dat_i[7:0] & `HSIM_MASK_USED;
		end
	end

	// Global enable; lets software quiet the line without losing the mask
	always @(posedge core_clk) begin
		if (reset) begin
			irqEnable <= `HSIM_IRQEN_RESET;
		end else if (writeEnable) begin
			irqEnable <= wb_dat_i[0];
		end
	end

	// Transmit message done
	// Held until the status read, so a one-cycle pulse is never missed
	always @(posedge core_clk) begin
		if (reset) begin
			txMessageDoneFlag <= 1'b0;
		end else begin
			txMessageDoneFlag <= latch_next(txMessageDoneFlag, txMessageDone, readStatus);
		end
	end

	// Receive packet start
	// Cleared by the same status read that reports it
	always @(posedge core_clk) begin
		if (reset) begin
			rxPacketStartFlag <= 1'b0;
		end else begin
			rxPacketStartFlag <= latch_next(rxPacketStartFlag, rxPacketStart, readStatus);
		end
	end

	// Receive packet end
	// A new end in the reading cycle keeps the flag for the next read
	always @(posedge core_clk) begin
		if (reset) begin
			rxPacketEndFlag <= 1'b0;
		end else begin
			rxPacketEndFlag <= latch_next(rxPacketEndFlag, rxPacketEnd, readStatus);
		end
	end

	// Receive abort seen
	// Cleared only by an info read, status reads leave it alone
	always @(posedge core_clk) begin
		if (reset) begin
			rxAbortFlag <= 1'b0;
		end else begin
			rxAbortFlag <= latch_next(rxAbortFlag, rxAbortSeen, readInfo);
		end
	end

	// Receive CRC error
	// Stays set across several frames until software looks
	always @(posedge core_clk) begin
		if (reset) begin
			rxCrcFlag <= 1'b0;
		end else begin
			rxCrcFlag <= latch_next(rxCrcFlag, rxCrcError, readInfo);
		end
	end

	// Receive overrun
	// Sticky so that a lost byte is reported even after recovery
	always @(posedge core_clk) begin
		if (reset) begin
			rxOverrunFlag <= 1'b0;
		end else begin
			rxOverrunFlag <= latch_next(rxOverrunFlag, rxOverrun, readInfo);
		end
	end

	// Receive valid frame
	// Reported once per info read, then cleared
	always @(posedge core_clk) begin
		if (reset) begin
			rxValidFlag <= 1'b0;
		end else begin
			rxValidFlag <= latch_next(rxValidFlag, rxValidFrame, readInfo);
		end
	end

	// Per-source request: each status bit gated by its own mask bit
	// Bit 7 has no source, so it never reaches the line
	assign pendingSources[0] = statusWord[0] & irqMask[0];
	assign pendingSources[1] = statusWord[1] & irqMask[1];
	assign pendingSources[2] = statusWord[2] & irqMask[2];
	assign pendingSources[3] = statusWord[3] & irqMask[3];
	assign pendingSources[4] = statusWord[4] & irqMask[4];
	assign pendingSources[5] = statusWord[5] & irqMask[5];
	assign pendingSources[6] = statusWord[6] & irqMask[6];

	// Level output, registered so the pin never glitches
	// Follows a status bit one cycle late; sticky events and levels each add one more cycle
	always @(posedge core_clk) begin
		if (reset) begin
			hdlcIrq <= 1'b0;
		end else begin
			hdlcIrq <= irqEnable & (|pendingSources);
		end
	end
endmodule // hsim_status_irq

// >>> test/hsim_status_irq_props.sv
// Port checker for the status and mask block
`timescale 1ns/1ns
module hsim_status_irq_props (
	// Bus and levels
	input wire core_clk,
	input wire reset,
	input wire wb_cyc_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [6:0] rxFifoCount,
	input wire [6:0] txFifoCount,
	input wire headIsFirst,
	input wire headIsLast
);
	reg [7:0] tA;
	reg tR;
	always @(posedge core_clk) begin
		tA <= wb_adr_i;
		tR <= wb_cyc_i & ~wb_we_i & ~wb_ack_o;
	end
	wire rS = wb_ack_o & tR & (tA == 8'hB1);
	wire rI = wb_ack_o & tR & (tA == 8'hB3);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("long ack");
	property p_ans; wb_cyc_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ans: assert property (p_ans) else $error("no ack");
	property p_rm; rS |-> wb_dat_o[1] == ($past(txFifoCount, 2) < 64); endproperty
	a_rm: assert property (p_rm) else $error("room");
	property p_th; rS |-> wb_dat_o[2] == ($past(txFifoCount, 2) < 32); endproperty
	a_th: assert property (p_th) else $error("tx half");
	property p_rh; rS |-> wb_dat_o[4] == ($past(rxFifoCount, 2) > 32); endproperty
	a_rh: assert property (p_rh) else $error("rx half");
	property p_em; rI |-> wb_dat_o[3] == ($past(rxFifoCount, 2) == 0); endproperty
	a_em: assert property (p_em) else $error("empty");
	property p_hd; rI |-> wb_dat_o[1:0] == {$past(headIsLast), $past(headIsFirst)}; endproperty
	a_hd: assert property (p_hd) else $error("head");
	property p_mt; wb_ack_o && tR && tA == 8'hB2 |-> !wb_dat_o[7]; endproperty
	a_mt: assert property (p_mt) else $error("mask top");
endmodule // hsim_status_irq_props
bind hsim_status_irq hsim_status_irq_props hsim_status_irq_props_i (.core_clk(core_clk),
	.reset(reset), .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxFifoCount(rxFifoCount),
	.txFifoCount(txFifoCount), .headIsFirst(headIsFirst), .headIsLast(headIsLast));

// >>> test/hsim_eng_model.sv
// Framing engine model giving one-cycle event pulses
`timescale 1ns/1ns
module hsim_eng_model (
	// Clock and events
	input wire core_clk,
	output reg [6:0] ev
);
	initial ev = 7'h00;
	task pulse(input [6:0] v);
		begin
			ev <= v;
			@(posedge core_clk);
			ev <= 7'h00;
		end
	endtask
endmodule // hsim_eng_model

// >>> test/test_hsim_status_irq.sv
// Bench for the status and mask block
`timescale 1ns/1ns
module test_hsim_status_irq;
	reg core_clk = 1'b0, reset = 1'b1, cyc = 1'b0, we = 1'b0;
	reg [7:0] adr = 8'h00, wd = 8'h00, d;
	reg [6:0] rxC = 7'h00, txC = 7'h00;
	reg [2:0] hd = 3'h0;
	wire [31:0] rd;
	wire [6:0] ev;
	wire ack, irq;
	integer error_cnt = 0, compares = 0, i;
	always #4 core_clk = ~core_clk;
	hsim_eng_model hsim_eng_model_i (.core_clk(core_clk), .ev(ev));
	hsim_status_irq hsim_status_irq_i (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i({24'h0, wd}), .wb_sel_i(4'h1),
		.wb_dat_o(rd), .wb_ack_o(ack), .rxFifoCount(rxC), .txFifoCount(txC),
		.txMessageDone(ev[0]), .rxPacketStart(ev[1]), .rxPacketEnd(ev[2]), .rxAbortSeen(ev[3]),
		.rxCrcError(ev[4]), .rxOverrun(ev[5]), .rxValidFrame(ev[6]), .headIsFirst(hd[0]),
		.headIsLast(hd[1]), .headIsGood(hd[2]), .hdlcIrq(irq));
	task bus(input w, input [7:0] a, input [7:0] v);
		begin
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			wd <= v;
			@(posedge core_clk);
			while (ack !== 1'b1) @(posedge core_clk);
			d = rd[7:0];
			cyc <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task chk(input [7:0] n, input [7:0] e, input [7:0] s);
		begin
			compares = compares + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("mismatch reg %h exp %h got %h", n, e, s);
			end
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			bus(1'b0, a, 8'h00);
			chk(a, e, d);
		end
	endtask
	task lv(input [6:0] r, input [6:0] t, input [7:0] e);
		begin
			rxC <= r;
			txC <= t;
			@(posedge core_clk);
			rc(8'hB1, e);
		end
	endtask
	task wrap_up;
		begin
			$display("errors %0d compares %0d", error_cnt, compares);
			if (error_cnt == 0 && compares > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rc(8'hB3, 8'h08);
		rc(8'hB1, 8'h06);
		bus(1'b1, 8'hB2, 8'hFF);
		rc(8'hB2, 8'h7F);
		rc(8'hC0, 8'h00);
		lv(7'h21, 7'h40, 8'h18);
		lv(7'h20, 7'h20, 8'h0A);
		lv(7'h01, 7'h1F, 8'h0E);
		hsim_eng_model_i.pulse(7'h7F);
		rc(8'hB1, 8'h6F);
		rc(8'hB1, 8'h0E);
		rc(8'hB3, 8'hF0);
		rc(8'hB3, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			hd <= i[2:0];
			rc(8'hB3, {5'h00, i[2] & i[1], i[1:0]});
		end
		bus(1'b1, 8'hB9, 8'h01);
		bus(1'b1, 8'hB2, 8'h01);
		chk(8'h00, 8'h00, {7'h00, irq});
		hsim_eng_model_i.pulse(7'h01);
		repeat (2) @(posedge core_clk);
		chk(8'h00, 8'h01, {7'h00, irq});
		bus(1'b1, 8'hB2, 8'h00);
		chk(8'h00, 8'h00, {7'h00, irq});
		bus(1'b1, 8'hB2, 8'h01);
		rc(8'hB1, 8'h0F);
		chk(8'h00, 8'h00, {7'h00, irq});
		wrap_up;
	end
endmodule // test_hsim_status_irq
